// ==== design/branch_skip_shift_decode.sv ====
// Executes jumps, calls, condition skips, compare/modify skips and shift decode.
// Assumes the CPU presents one request at a time with stable register state,
// and pulses other_retired whenever an instruction outside this block retires.
`timescale 1ns/10ps
module branch_skip_shift_decode (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire branch_skip_shift_pkg::req_t req,
  input wire branch_skip_shift_pkg::cpu_state_t state,
  input wire logic other_retired,
  output logic req_ready,
  output logic done,
  output branch_skip_shift_pkg::result_t result,
  output logic defer_break
);
  logic busy;
  logic [4:0] div;
  logic [5:0] tenths;
  logic [5:0] dur;
  logic [5:0] next_dur;
  logic hold_pending;
  branch_skip_shift_pkg::req_t cur;
  branch_skip_shift_pkg::result_t next_result;

  // Request acceptance
  wire start = req_valid && !busy;
  wire tick = busy && (div == branch_skip_shift_pkg::TENTH_CLKS - 5'h01);
  wire last_tick = tick && (tenths == dur - 6'h01);
  assign req_ready = !busy;

  // Skip condition test
  wire any_true;
  condition_eval u_cond (
    .mask(req.instr[8:0]),
    .state(state),
    .any_true(any_true)
  );

  // Skip sense; other z codes never skip
  wire [2:0] skip_z = req.instr[branch_skip_shift_pkg::Z_LSB +: 3];
  wire skip_take = (skip_z == branch_skip_shift_pkg::Z_ANY) ? any_true : // see RULE7
                   (skip_z == branch_skip_shift_pkg::Z_NONE) ? !any_true : 1'b0; // see RULE10

  // Signed compare against the selected register
  wire [15:0] cmp_reg = (req.op == branch_skip_shift_pkg::compare_a_skip) ? state.a :
                        (req.op == branch_skip_shift_pkg::compare_b_skip) ? state.b : state.x;
  wire cmp_gt = $signed(cmp_reg) > $signed(req.operand); // see RULE19
  wire cmp_eq = (cmp_reg == req.operand);
  wire [15:0] cmp_words = cmp_gt ? 16'h0002 : (cmp_eq ? 16'h0001 : 16'h0000); // see RULE12

  // Modify results; overflow is never touched by this block
  wire [8:0] imm9 = req.instr[8:0];
  wire [15:0] x_up = 16'(state.x + {7'h00, imm9}); // see RULE13
  wire [15:0] x_dn = 16'(state.x - {7'h00, ~imm9}); // see RULE14
  wire [15:0] mem_dn = 16'(req.operand - 16'h0001); // see RULE15

  // Shift field, indexed form adds X low bits and wraps at nine bits
  wire [8:0] shift_src = (req.op == branch_skip_shift_pkg::shift_indexed) ?
                         9'(req.instr[8:0] + state.x[8:0]) : req.instr[8:0]; // see RULE17
  wire [3:0] kind_code = shift_src[branch_skip_shift_pkg::KIND_LSB +: 4]; // see RULE16
  wire [4:0] count_code = shift_src[branch_skip_shift_pkg::COUNT_LSB +: 5];
  wire [15:0] pc_one = 16'(req.pc + branch_skip_shift_pkg::LEN_ONE);
  wire [15:0] pc_two = 16'(req.pc + branch_skip_shift_pkg::LEN_TWO);
  wire [15:0] ea_one = 16'(req.ea + 16'h0001);

  // Shift kind decode; code 15 has no defined meaning
  branch_skip_shift_pkg::shift_t kind;
  always_comb begin
    unique case (kind_code)
      4'h0: kind = branch_skip_shift_pkg::asl_a; // see RULE18
      4'h1: kind = branch_skip_shift_pkg::lsl_a;
      4'h2: kind = branch_skip_shift_pkg::asr_a;
      4'h3: kind = branch_skip_shift_pkg::lsr_a;
      4'h4: kind = branch_skip_shift_pkg::asl_b;
      4'h5: kind = branch_skip_shift_pkg::lsl_b;
      4'h6: kind = branch_skip_shift_pkg::asr_b;
      4'h7: kind = branch_skip_shift_pkg::lsr_b;
      4'h8: kind = branch_skip_shift_pkg::asl_ab;
      4'h9: kind = branch_skip_shift_pkg::lsl_ab;
      4'hA: kind = branch_skip_shift_pkg::asr_ab;
      4'hB: kind = branch_skip_shift_pkg::lsr_ab;
      4'hC: kind = branch_skip_shift_pkg::rol_a;
      4'hD: kind = branch_skip_shift_pkg::rol_b;
      4'hE: kind = branch_skip_shift_pkg::rol_ab;
      default: kind = branch_skip_shift_pkg::shift_illegal;
    endcase
  end

  // Outcome and duration of the request being accepted
  always_comb begin
    next_result = '0;
    next_result.next_pc = pc_one;
    next_result.mem_addr = req.ea;
    next_result.shift_kind = kind;
    next_result.shift_count = count_code;
    next_dur = branch_skip_shift_pkg::DUR_SKIP;
    unique case (req.op)
      branch_skip_shift_pkg::jump_long: begin
        next_result.next_pc = req.ea; // see RULE1
        next_dur = branch_skip_shift_pkg::DUR_LONG;
      end
      branch_skip_shift_pkg::jump_short: begin
        next_result.next_pc = req.ea; // see RULE1
        next_dur = branch_skip_shift_pkg::DUR_SHORT;
      end
      branch_skip_shift_pkg::call_long: begin
        next_result.mem_we = 1'b1;
        next_result.mem_wdata = pc_two; // see RULE3
        next_result.next_pc = ea_one; // see RULE4
        next_dur = branch_skip_shift_pkg::DUR_LONG;
      end
      branch_skip_shift_pkg::call_short: begin
        next_result.mem_we = 1'b1;
        next_result.mem_wdata = pc_one; // see RULE2
        next_result.next_pc = ea_one; // see RULE4
        next_dur = branch_skip_shift_pkg::DUR_SHORT;
      end
      branch_skip_shift_pkg::skip_cond: begin
        // One word only; a two-word successor would be split (see RULE11)
        next_result.next_pc = skip_take ? pc_two : pc_one; // see RULE9
      end
      branch_skip_shift_pkg::compare_a_skip,
      branch_skip_shift_pkg::compare_b_skip,
      branch_skip_shift_pkg::compare_x_skip: begin
        next_result.next_pc = 16'(pc_two + cmp_words); // see RULE12
        next_dur = branch_skip_shift_pkg::DUR_LONG;
      end
      branch_skip_shift_pkg::index_up_skip_zero: begin
        next_result.x_we = 1'b1;
        next_result.x_wdata = x_up;
        next_result.next_pc = (x_up == 16'h0000) ? pc_two : pc_one; // see RULE13
        next_dur = branch_skip_shift_pkg::DUR_MODX;
      end
      branch_skip_shift_pkg::index_down_skip_zero: begin
        next_result.x_we = 1'b1;
        next_result.x_wdata = x_dn;
        next_result.next_pc = (x_dn == 16'h0000) ? pc_two : pc_one; // see RULE14
        next_dur = branch_skip_shift_pkg::DUR_MODX;
      end
      branch_skip_shift_pkg::memory_down_skip_zero: begin
        next_result.mem_we = 1'b1;
        next_result.mem_wdata = mem_dn; // see RULE15
        next_result.next_pc = (mem_dn == 16'h0000) ? 16'(pc_two + 16'h0001) : pc_two;
        next_dur = branch_skip_shift_pkg::DUR_MEMDN;
      end
      branch_skip_shift_pkg::shift_direct,
      branch_skip_shift_pkg::shift_indexed: begin
        next_result.shift_valid = 1'b1; // see RULE16
        next_dur = branch_skip_shift_pkg::DUR_SHIFT;
      end
    endcase
  end

  // Call in flight or just retired keeps interrupts and halts off
  wire cur_is_call = (cur.op == branch_skip_shift_pkg::call_long) ||
                     (cur.op == branch_skip_shift_pkg::call_short);
  assign defer_break = (busy && cur_is_call) || hold_pending; // see RULE5

  // Latch request and outcome; result changes only at acceptance
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '0;
      result <= '0;
      dur <= 6'h01;
    end else if (start) begin
      cur <= req;
      result <= next_result;
      dur <= next_dur;
    end
  end

  // Tenth-cycle divider and elapsed count, restarted per request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      div <= 5'h00;
      tenths <= 6'h00;
    end else if (start) begin
      busy <= 1'b1;
      div <= 5'h00;
      tenths <= 6'h00;
    end else if (last_tick) begin
      busy <= 1'b0;
    end else if (tick) begin
      div <= 5'h00;
      tenths <= 6'(tenths + 6'h01);
    end else if (busy) begin
      div <= 5'(div + 5'h01);
    end
  end

  // Done pulses in the final clock of the instruction's time
  assign done = last_tick;

  // Pending hold: a retiring call sets it and wins over a clear
  wire next_retire = (done && !cur_is_call) || other_retired;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_pending <= 1'b0;
    end else if (done && cur_is_call) begin
      hold_pending <= 1'b1; // see RULE6
    end else if (next_retire) begin
      hold_pending <= 1'b0;
    end
  end

  // Helper: clocks since acceptance, for timing checks
  logic [9:0] run_clks;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_clks <= 10'h000;
    end else if (start) begin
      run_clks <= 10'h000;
    end else if (busy) begin
      run_clks <= 10'(run_clks + 10'h001);
    end
  end

  // Helper: skip condition at acceptance
  logic any_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      any_q <= 1'b0;
    end else if (start) begin
      any_q <= any_true;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_call_done;
    done && cur_is_call;
  endsequence

  sequence s_hold_until_retire;
    // A retire pulse only clears the hold at the edge after it, so two cycles stand
    defer_break [*2];
  endsequence

  jump_target_a: assert property ((done && (cur.op == branch_skip_shift_pkg::jump_long ||
      cur.op == branch_skip_shift_pkg::jump_short)) |-> result.next_pc == cur.ea) // see RULE1
    else $error("jump does not land on effective address");
  jump_long_time_a: assert property ((done && cur.op == branch_skip_shift_pkg::jump_long)
      |-> run_clks == 10'd479) // see RULE1
    else $error("long jump time wrong");
  call_short_link_a: assert property ((done && cur.op == branch_skip_shift_pkg::call_short)
      |-> result.mem_we && result.mem_wdata == 16'(cur.pc + 16'h0001) && run_clks == 10'd319) // see RULE2
    else $error("short call link or time wrong");
  call_long_link_a: assert property ((done && cur.op == branch_skip_shift_pkg::call_long)
      |-> result.mem_wdata == 16'(cur.pc + 16'h0002) && result.mem_addr == cur.ea) // see RULE3
    else $error("long call link wrong");
  call_return_a: assert property (s_call_done |-> result.next_pc == 16'(cur.ea + 16'h0001)) // see RULE4
    else $error("call does not continue after link word");
  call_defer_a: assert property ((s_call_done ##1 !other_retired && !start) |-> s_hold_until_retire) // see RULE5
    else $error("break not deferred after call");
  skip_sense_a: assert property ((start && req.op == branch_skip_shift_pkg::skip_cond &&
      skip_z == branch_skip_shift_pkg::Z_ANY) |=> result.next_pc == 16'(cur.pc + (any_q ? 16'h0002 : 16'h0001))) // see RULE9
    else $error("skip any true took wrong path");
  compare_skip_a: assert property ((start && req.op == branch_skip_shift_pkg::compare_x_skip)
      |=> result.next_pc == 16'(cur.pc + 16'h0002 + $past(cmp_words)) && dur == 6'h1E) // see RULE12
    else $error("compare skip count wrong");
  index_zero_a: assert property ((done && cur.op == branch_skip_shift_pkg::index_up_skip_zero)
      |-> (result.next_pc == 16'(cur.pc + 16'h0002)) == (result.x_wdata == 16'h0000) && run_clks == 10'd223) // see RULE13
    else $error("index up skip or time wrong");
  shift_index_a: assert property ((start && req.op == branch_skip_shift_pkg::shift_indexed)
      |=> result.shift_count == 5'($past(req.instr[4:0]) + $past(state.x[4:0])) && result.shift_valid) // see RULE17
    else $error("indexed shift count wrong");

endmodule

// ==== design/branch_skip_shift_pkg.sv ====
// Constants, field layouts, operation codes and carrier structs for the
// jump, call, skip and shift decode block.
// Assumes the surrounding CPU supplies decoded operation class and operands.
// Contract
// RULE1: Jumps go to the effective address; long takes three cycles, short two.
// RULE2: Short call stores program counter plus one at the effective address, two cycles.
// RULE3: Long call stores program counter plus two at the effective address, three cycles.
// RULE4: After either call, execution continues at effective address plus one.
// RULE5: Interrupt during a call waits until one further instruction has run.
// RULE6: In single-step or variable speed, a call runs the next instruction before halting.
// RULE7: Skip field 4 skips on any condition true, 5 on all false.
// RULE8: Nine mask bits: switches 1-4, overflow, A positive, A zero, B zero, X zero.
// RULE9: Skip-any-true skips one word when a selected condition holds, one cycle.
// RULE10: Skip-all-false skips one word only when none holds, one cycle.
// RULE11: Programs should put only a single-word instruction after any skip.
// RULE12: Compare: less continues, equal skips one, greater skips two, three cycles.
// RULE13: Index up adds the 9-bit count to X, skips on zero, overflow untouched, 1.4 cycles.
// RULE14: Index down subtracts the complemented 9-bit field, skips on zero, overflow untouched.
// RULE15: Memory down subtracts one, stores it, skips on zero, four cycles.
// RULE16: Direct shift carries a shift kind field and a 0 to 31 count.
// RULE17: Indexed shift adds low nine bits of X to the instruction's low nine bits.
// RULE18: Shift kinds decode to A, B, A-B pair forms and rotates of A and B.
// RULE19: Comparisons and sign tests treat words as two's complement signed values.
package branch_skip_shift_pkg;

  localparam int WORD_W = 16;
  localparam int MASK_W = 9;

  // Clocks per tenth of a memory cycle; lets 1.4 cycle timing be exact
  localparam logic [4:0] TENTH_CLKS = 5'h10;
  // Durations in tenths of a memory cycle
  localparam logic [5:0] DUR_LONG = 6'h1E;
  localparam logic [5:0] DUR_SHORT = 6'h14;
  localparam logic [5:0] DUR_SKIP = 6'h0A;
  localparam logic [5:0] DUR_MODX = 6'h0E;
  localparam logic [5:0] DUR_MEMDN = 6'h28;
  localparam logic [5:0] DUR_SHIFT = 6'h0A;

  // Instruction word fields
  localparam int Z_LSB = 9;
  localparam int KIND_LSB = 5;
  localparam int COUNT_LSB = 0;
  localparam logic [2:0] Z_ANY = 3'h4;
  localparam logic [2:0] Z_NONE = 3'h5;

  // Condition mask bit positions
  localparam int CC_SW1 = 0;
  localparam int CC_OVF = 4;
  localparam int CC_APOS = 5;
  localparam int CC_AZERO = 6;
  localparam int CC_BZERO = 7;
  localparam int CC_XZERO = 8;

  // Instruction lengths in words
  localparam logic [15:0] LEN_ONE = 16'h0001;
  localparam logic [15:0] LEN_TWO = 16'h0002;

  typedef enum logic [3:0] {
    jump_long, jump_short, call_long, call_short, skip_cond,
    compare_a_skip, compare_b_skip, compare_x_skip,
    index_up_skip_zero, index_down_skip_zero, memory_down_skip_zero,
    shift_direct, shift_indexed
  } op_t;

  typedef enum logic [3:0] {
    asl_a, lsl_a, asr_a, lsr_a, asl_b, lsl_b, asr_b, lsr_b,
    asl_ab, lsl_ab, asr_ab, lsr_ab, rol_a, rol_b, rol_ab, shift_illegal
  } shift_t;

  typedef struct packed {
    op_t op;
    logic [15:0] instr;
    logic [15:0] pc;
    logic [15:0] ea;
    logic [15:0] operand;
  } req_t;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] x;
    logic ovf;
    logic [3:0] switches;
  } cpu_state_t;

  typedef struct packed {
    logic [15:0] next_pc;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic x_we;
    logic [15:0] x_wdata;
    logic shift_valid;
    shift_t shift_kind;
    logic [4:0] shift_count;
  } result_t;

endpackage

// ==== design/condition_eval.sv ====
// Skip condition evaluator: one test per mask bit, ORed together.
// Assumes register state is stable while the request is presented.
`timescale 1ns/10ps
module condition_eval (
  input wire logic [8:0] mask,
  input wire branch_skip_shift_pkg::cpu_state_t state,
  output logic any_true
);
  logic [8:0] test;
  logic [8:0] hit;

  // Raw tests; A positive means nonzero with sign clear (see RULE19)
  assign test[3:0] = state.switches; // see RULE8
  assign test[branch_skip_shift_pkg::CC_OVF] = state.ovf;
  assign test[branch_skip_shift_pkg::CC_APOS] = !state.a[15] && (state.a != 16'h0000);
  assign test[branch_skip_shift_pkg::CC_AZERO] = (state.a == 16'h0000);
  assign test[branch_skip_shift_pkg::CC_BZERO] = (state.b == 16'h0000);
  assign test[branch_skip_shift_pkg::CC_XZERO] = (state.x == 16'h0000);

  // Only selected tests count; an empty mask selects nothing
  genvar i;
  generate
    for (i = 0; i < branch_skip_shift_pkg::MASK_W; i++) begin : g_hit
      assign hit[i] = mask[i] && test[i]; // see RULE8
    end
  endgenerate

  assign any_true = |hit;
endmodule

// ==== sim/branch_skip_shift_decode_bench.sv ====
// Self-checking bench for the jump, call, skip, compare, modify and shift decode block.
// Assumes the design package is compiled first; the bench drives every port itself.
`timescale 1ns/10ps
module branch_skip_shift_decode_bench;
  // Ceiling on the run; the planned sequence needs roughly half of it
  localparam int LIMIT = 40000;
  localparam int TC = int'(branch_skip_shift_pkg::TENTH_CLKS);
  localparam int N_LONG = int'(branch_skip_shift_pkg::DUR_LONG) * TC;
  localparam int N_SHORT = int'(branch_skip_shift_pkg::DUR_SHORT) * TC;
  localparam int N_SKIP = int'(branch_skip_shift_pkg::DUR_SKIP) * TC;
  localparam int N_MODX = int'(branch_skip_shift_pkg::DUR_MODX) * TC;
  localparam int N_MEMDN = int'(branch_skip_shift_pkg::DUR_MEMDN) * TC;
  localparam int N_SHIFT = int'(branch_skip_shift_pkg::DUR_SHIFT) * TC;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic other_retired = 1'b0;
  branch_skip_shift_pkg::req_t req = '0;
  branch_skip_shift_pkg::cpu_state_t state = '0;
  branch_skip_shift_pkg::cpu_state_t st;
  branch_skip_shift_pkg::op_t cmp_ops [3];
  logic req_ready;
  logic done;
  logic defer_break;
  branch_skip_shift_pkg::result_t result;
  int errors = 0;
  int checks = 0;
  int cycles = 0;

  branch_skip_shift_decode i_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .req_valid(req_valid),
    .req(req),
    .state(state),
    .other_retired(other_retired),
    .req_ready(req_ready),
    .done(done),
    .result(result),
    .defer_break(defer_break)
  );

  always #4 clk = ~clk;

  // Hang guard: a stuck handshake must still reach the verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // All conditions false: switches off, no overflow, A negative, B and X nonzero
  function automatic branch_skip_shift_pkg::cpu_state_t base_state();
    branch_skip_shift_pkg::cpu_state_t s;
    s = '0;
    s.a = 16'h8000;
    s.b = 16'h0001;
    s.x = 16'h0001;
    return s;
  endfunction

  // One request: wait for idle, hold valid through the accept edge, then time the run to done
  task automatic run_op(input branch_skip_shift_pkg::op_t op, input logic [15:0] instr, input logic [15:0] pc,
                        input logic [15:0] ea, input logic [15:0] operand, input int n_clk,
                        input logic [15:0] exp_pc);
    int i;
    int cnt;
    i = 0;
    while (req_ready !== 1'b1 && i < 1000) begin
      @(posedge clk);
      #1;
      i++;
    end
    req.op = op;
    req.instr = instr;
    req.pc = pc;
    req.ea = ea;
    req.operand = operand;
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    cnt = 0;
    while (done !== 1'b1 && cnt < 2000) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    chk(16'(cnt), 16'(n_clk - 1));
    chk(result.next_pc, exp_pc);
  endtask

  // Skip on one mask bit; bit 9 stands for the empty mask
  task automatic skip_run(input int bit_i, input logic hit, input logic [2:0] z);
    logic [8:0] mask;
    logic taken;
    st = base_state();
    mask = (bit_i < 9) ? (9'h001 << bit_i) : 9'h000;
    if (hit) begin
      if (bit_i < 4) st.switches[bit_i] = 1'b1;
      else if (bit_i == 4) st.ovf = 1'b1;
      else if (bit_i == 5) st.a = 16'h0005;
      else if (bit_i == 6) st.a = 16'h0000;
      else if (bit_i == 7) st.b = 16'h0000;
      else st.x = 16'h0000;
    end
    state = st;
    taken = (z == 3'h4 && hit) || (z == 3'h5 && !hit);
    // Successor is taken as one word, so a skip steps exactly one word
    run_op(branch_skip_shift_pkg::skip_cond, {4'h0, z, mask}, 16'h0040, 16'h0000, 16'h0000, N_SKIP,
           taken ? 16'h0042 : 16'h0041);
  endtask

  // Main sequence
  initial begin
    cmp_ops[0] = branch_skip_shift_pkg::compare_a_skip;
    cmp_ops[1] = branch_skip_shift_pkg::compare_b_skip;
    cmp_ops[2] = branch_skip_shift_pkg::compare_x_skip;
    state = base_state();
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    run_op(branch_skip_shift_pkg::jump_long, 16'h0000, 16'h0010, 16'h0123, 16'h0000, N_LONG, 16'h0123);
    chk({15'h0, defer_break}, 16'h0000);
    run_op(branch_skip_shift_pkg::jump_short, 16'h0000, 16'h0010, 16'h0456, 16'h0000, N_SHORT, 16'h0456);
    // Calls: link word, landing address, then the hold on interrupts and halts
    run_op(branch_skip_shift_pkg::call_short, 16'h0000, 16'h0200, 16'h0300, 16'h0000, N_SHORT, 16'h0301);
    chk({15'h0, result.mem_we}, 16'h0001);
    chk(result.mem_addr, 16'h0300);
    chk(result.mem_wdata, 16'h0201);
    chk({15'h0, defer_break}, 16'h0001);
    run_op(branch_skip_shift_pkg::call_long, 16'h0000, 16'h0200, 16'h0310, 16'h0000, N_LONG, 16'h0311);
    chk(result.mem_wdata, 16'h0202);
    chk(result.mem_addr, 16'h0310);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0, defer_break}, 16'h0001);
    skip_run(9, 1'b0, 3'h4);
    @(posedge clk);
    #1;
    chk({15'h0, defer_break}, 16'h0000);
    run_op(branch_skip_shift_pkg::call_short, 16'h0000, 16'h0500, 16'h0600, 16'h0000, N_SHORT, 16'h0601);
    // A retire in the call's own last cycle must not clear the hold; the next one does
    other_retired = 1'b1;
    @(posedge clk);
    #1;
    chk({15'h0, defer_break}, 16'h0001);
    @(posedge clk);
    #1;
    other_retired = 1'b0;
    @(posedge clk);
    #1;
    chk({15'h0, defer_break}, 16'h0000);
    // Every mask bit, both senses, condition true and false
    for (int b = 0; b < 9; b++) begin
      skip_run(b, 1'b1, 3'h4);
      skip_run(b, 1'b0, 3'h4);
      skip_run(b, 1'b1, 3'h5);
      skip_run(b, 1'b0, 3'h5);
    end
    skip_run(9, 1'b0, 3'h5);
    skip_run(6, 1'b1, 3'h6);
    // Zero A is not positive
    st = base_state();
    st.a = 16'h0000;
    state = st;
    run_op(branch_skip_shift_pkg::skip_cond, 16'h0820, 16'h0040, 16'h0, 16'h0, N_SKIP, 16'h0041);
    // Signed compare: less, equal, greater for each register
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 3; k++) begin
        st = base_state();
        if (r == 0) st.a = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0003 : 16'h7FFF;
        if (r == 1) st.b = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0003 : 16'h7FFF;
        if (r == 2) st.x = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0003 : 16'h7FFF;
        state = st;
        run_op(cmp_ops[r], 16'h0000, 16'h0100, 16'h0200, (k == 0) ? 16'h0001 : (k == 1) ? 16'h0003 : 16'h8000,
               N_LONG, 16'(16'h0102 + k));
      end
    end
    // Index modify: a zero result skips, other results fall through
    st = base_state();
    st.x = 16'hFE01;
    state = st;
    run_op(branch_skip_shift_pkg::index_up_skip_zero, 16'h01FF, 16'h0050, 16'h0, 16'h0, N_MODX, 16'h0052);
    chk(result.x_wdata, 16'h0000);
    chk({15'h0, result.x_we}, 16'h0001);
    st.x = 16'h0005;
    state = st;
    run_op(branch_skip_shift_pkg::index_up_skip_zero, 16'h0003, 16'h0050, 16'h0, 16'h0, N_MODX, 16'h0051);
    chk(result.x_wdata, 16'h0008);
    st.x = 16'h01FE;
    state = st;
    run_op(branch_skip_shift_pkg::index_down_skip_zero, 16'h0001, 16'h0050, 16'h0, 16'h0, N_MODX, 16'h0052);
    chk(result.x_wdata, 16'h0000);
    st.x = 16'h0010;
    state = st;
    run_op(branch_skip_shift_pkg::index_down_skip_zero, 16'h01FF, 16'h0050, 16'h0, 16'h0, N_MODX, 16'h0051);
    chk(result.x_wdata, 16'h0010);
    // Memory decrement: to zero skips, wrap to all ones does not
    run_op(branch_skip_shift_pkg::memory_down_skip_zero, 16'h0, 16'h0070, 16'h0400, 16'h0001, N_MEMDN, 16'h0073);
    chk(result.mem_wdata, 16'h0000);
    chk(result.mem_addr, 16'h0400);
    chk({15'h0, result.mem_we}, 16'h0001);
    run_op(branch_skip_shift_pkg::memory_down_skip_zero, 16'h0, 16'h0070, 16'h0400, 16'h0000, N_MEMDN, 16'h0072);
    chk(result.mem_wdata, 16'hFFFF);
    // Every shift kind, counts up to the 31 boundary
    state = base_state();
    for (int s = 0; s < 16; s++) begin
      run_op(branch_skip_shift_pkg::shift_direct, 16'({s[3:0], 5'(31 - s)}), 16'h0090, 16'h0, 16'h0, N_SHIFT,
             16'h0091);
      chk({12'h0, result.shift_kind}, 16'(s));
      chk({11'h0, result.shift_count}, 16'(31 - s));
      chk({15'h0, result.shift_valid}, 16'h0001);
    end
    // Indexed shift: nine-bit sum wraps before it is split
    st = base_state();
    st.x = 16'h0025;
    state = st;
    run_op(branch_skip_shift_pkg::shift_indexed, 16'h01F0, 16'h0090, 16'h0, 16'h0, N_SHIFT, 16'h0091);
    chk({12'h0, result.shift_kind}, 16'h0000);
    chk({11'h0, result.shift_count}, 16'h0015);
    st.x = 16'hFE20;
    state = st;
    run_op(branch_skip_shift_pkg::shift_indexed, 16'h0020, 16'h0090, 16'h0, 16'h0, N_SHIFT, 16'h0091);
    chk({12'h0, result.shift_kind}, 16'h0002);
    chk({11'h0, result.shift_count}, 16'h0000);
    final_report();
  end
endmodule
